// ### src/osc_trim_spread_spectrum.sv
`default_nettype none
// What this block does
// - sweep rate zero disables spreading; drive word equals programmed fine trim.
// - amplitude code 11/10/01/00 selects plus-minus 32/16/8/4 trim steps.
// - nonzero rate sweeps drive word over fine trim plus-minus amplitude.
// - rate sets the step interval in fast-oscillator cycles.
// - full sweep lasts four times rate times twice amplitude plus one fast cycles.
// - drive word saturates between 0 and 255.
// - fast oscillator stops in STOP or SLEEP, restarts on wake.
// - fine trim resets to 0x80, drives oscillator; larger means slower.
// - coarse trim resets to 01, selects the 16 or 32 MHz band.
// - slow clock divided by four feeds system clock, timer and watchdogs.
// - slow oscillator always enabled; no bit turns it off.
// - slow trim resets to 0x10, drives slow oscillator; software recalibrates.
module osc_trim_spread_spectrum (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        fast_osc_tick,
    input  wire logic        slow_clk_tick,
    input  wire logic        cpu_stop_or_sleep,
    input  wire logic [17:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [17:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [1:0]       coarse_trim,
    output logic [7:0]       trim_drive_out,
    output logic [4:0]       slow_trim_value,
    output logic             fast_osc_enable,
    output logic             slow_osc_enable,
    output logic             slow_quarter_tick
);
    logic [7:0]  coarse_spread_register;
    logic [7:0]  next_coarse_spread;
    logic [7:0]  fine_trim_value;
    logic [7:0]  next_fine_trim;
    logic [4:0]  slow_trim;
    logic [4:0]  next_slow_trim;
    logic        sleep_allow;
    logic        next_sleep_allow;
    logic        fast_run;
    logic        next_fast_run;

    logic        aw_held;
    logic        next_aw_held;
    logic [17:0] aw_addr;
    logic [17:0] next_aw_addr;
    logic        w_held;
    logic        next_w_held;
    logic [7:0]  w_byte;
    logic [7:0]  next_w_byte;
    logic        w_lane;
    logic        next_w_lane;
    logic        b_pend;
    logic        next_b_pend;
    logic [1:0]  b_resp;
    logic [1:0]  next_b_resp;
    logic        r_pend;
    logic        next_r_pend;
    logic [31:0] r_data;
    logic [31:0] next_r_data;
    logic [1:0]  r_resp;
    logic [1:0]  next_r_resp;

    logic [7:0]  swept_word;
    logic [6:0]  offset_abs;
    logic        sweeping;
    logic        do_write;

    function automatic logic [15:0] index_of(input logic [17:0] addr);
        return addr[17:2];
    endfunction : index_of

    function automatic logic known_index(input logic [15:0] idx);
        return idx == osc_trim_pkg::coarse_spread_index || idx == osc_trim_pkg::fine_trim_index
            || idx == osc_trim_pkg::slow_trim_index || idx == osc_trim_pkg::sleep_control_index;
    endfunction : known_index

    spread_sweep sweep_inst (
        .core_clk         (core_clk),
        .rst              (rst),
        .fast_osc_tick    (fast_osc_tick & fast_run),
        .sweep_rate       (coarse_spread_register[7:4]),
        .sweep_amplitude  (coarse_spread_register[3:2]),
        .fine_trim_value  (fine_trim_value),
        .fine_trim_word   (swept_word),
        .sweep_offset_abs (offset_abs),
        .sweep_active     (sweeping)
    );

    slow_clock_divider divider_inst (
        .slow_clk_tick     (slow_clk_tick),
        .core_clk          (core_clk),
        .rst               (rst),
        .slow_quarter_tick (slow_quarter_tick)
    );

    assign s_axi_awready = !aw_held && !b_pend;
    assign s_axi_wready  = !w_held && !b_pend;
    assign s_axi_arready = !r_pend;
    assign do_write      = aw_held && w_held && !b_pend;

    always_comb begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held  = w_held;
        next_w_byte  = w_byte;
        next_w_lane  = w_lane;
        next_b_pend  = b_pend;
        next_b_resp  = b_resp;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_byte = s_axi_wdata[7:0];
            next_w_lane = s_axi_wstrb[0];
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_b_pend  = 1'b1;
            next_b_resp  = known_index(index_of(aw_addr)) ? osc_trim_pkg::axi_okay
                                                          : osc_trim_pkg::axi_slverr;
        end
        if (b_pend && s_axi_bready) begin
            next_b_pend = 1'b0;
        end
    end

    always_comb begin
        next_coarse_spread = coarse_spread_register;
        next_fine_trim     = fine_trim_value;
        next_slow_trim     = slow_trim;
        next_sleep_allow   = sleep_allow;
        if (do_write && w_lane) begin
            if (index_of(aw_addr) == osc_trim_pkg::coarse_spread_index) begin
                next_coarse_spread = w_byte;
            end else if (index_of(aw_addr) == osc_trim_pkg::fine_trim_index) begin
                next_fine_trim = w_byte;
            end else if (index_of(aw_addr) == osc_trim_pkg::slow_trim_index) begin
                next_slow_trim = w_byte[4:0];
            end else if (index_of(aw_addr) == osc_trim_pkg::sleep_control_index) begin
                next_sleep_allow = w_byte[0];
            end
        end
    end

    always_comb begin
        next_r_pend = r_pend;
        next_r_data = r_data;
        next_r_resp = r_resp;
        if (s_axi_arvalid && s_axi_arready) begin
            next_r_pend = 1'b1;
            next_r_resp = osc_trim_pkg::axi_okay;
            if (index_of(s_axi_araddr) == osc_trim_pkg::coarse_spread_index) begin
                next_r_data = {24'h000000, coarse_spread_register};
            end else if (index_of(s_axi_araddr) == osc_trim_pkg::fine_trim_index) begin
                next_r_data = {24'h000000, fine_trim_value};
            end else if (index_of(s_axi_araddr) == osc_trim_pkg::slow_trim_index) begin
                next_r_data = {27'h0000000, slow_trim};
            end else if (index_of(s_axi_araddr) == osc_trim_pkg::sleep_control_index) begin
                // live state: drive word, offset magnitude, sweeping, oscillator running
                next_r_data = {6'h00, fast_run, sweeping, 1'b0, offset_abs, swept_word,
                               7'h00, sleep_allow};
            end else begin
                next_r_data = 32'h00000000;
                next_r_resp = osc_trim_pkg::axi_slverr;
            end
        end else if (r_pend && s_axi_rready) begin
            next_r_pend = 1'b0;
        end
    end

    // stop and sleep always halt the oscillator; sleep_allow is only a readable flag
    always_comb begin
        next_fast_run = !cpu_stop_or_sleep;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            aw_held                <= 1'b0;
            aw_addr                <= 18'h00000;
            w_held                 <= 1'b0;
            w_byte                 <= 8'h00;
            w_lane                 <= 1'b0;
            b_pend                 <= 1'b0;
            b_resp                 <= 2'h0;
            r_pend                 <= 1'b0;
            r_data                 <= 32'h00000000;
            r_resp                 <= 2'h0;
            coarse_spread_register <= osc_trim_pkg::coarse_spread_reset;
            fine_trim_value        <= osc_trim_pkg::fine_trim_reset;
            slow_trim              <= osc_trim_pkg::slow_trim_reset;
            sleep_allow            <= 1'b1;
            fast_run               <= 1'b1;
        end else begin
            aw_held                <= next_aw_held;
            aw_addr                <= next_aw_addr;
            w_held                 <= next_w_held;
            w_byte                 <= next_w_byte;
            w_lane                 <= next_w_lane;
            b_pend                 <= next_b_pend;
            b_resp                 <= next_b_resp;
            r_pend                 <= next_r_pend;
            r_data                 <= next_r_data;
            r_resp                 <= next_r_resp;
            coarse_spread_register <= next_coarse_spread;
            fine_trim_value        <= next_fine_trim;
            slow_trim              <= next_slow_trim;
            sleep_allow            <= next_sleep_allow;
            fast_run               <= next_fast_run;
        end
    end

    assign s_axi_bvalid    = b_pend;
    assign s_axi_bresp     = b_resp;
    assign s_axi_rvalid    = r_pend;
    assign s_axi_rdata     = r_data;
    assign s_axi_rresp     = r_resp;
    assign coarse_trim     = coarse_spread_register[1:0];
    // swept word equals fine trim when sweeping is off; higher value slows the oscillator
    assign trim_drive_out  = swept_word;
    assign slow_trim_value = slow_trim;
    assign fast_osc_enable = fast_run;
    assign slow_osc_enable = 1'b1;
endmodule : osc_trim_spread_spectrum
`default_nettype wire

// ### shared/osc_trim_pkg.sv
`default_nettype none
package osc_trim_pkg;
    // printed offsets are not multiples of four: they are indexes, byte address = 4 * index
    localparam logic [15:0] coarse_spread_index = 16'ha001;
    localparam logic [15:0] fine_trim_index     = 16'ha002;
    localparam logic [15:0] slow_trim_index     = 16'ha007;
    localparam logic [15:0] sleep_control_index = 16'ha008;
    localparam int          addr_width          = 18;

    localparam logic [7:0] coarse_spread_reset = 8'h01;
    localparam logic [7:0] fine_trim_reset     = 8'h80;
    localparam logic [4:0] slow_trim_reset     = 5'h10;

    localparam int rate_lsb      = 4;
    localparam int rate_width    = 4;
    localparam int amp_lsb       = 2;
    localparam int coarse_lsb    = 0;

    localparam logic [1:0] slow_div_ratio_m1 = 2'h3;
    localparam logic [1:0] axi_okay          = 2'h0;
    localparam logic [1:0] axi_slverr        = 2'h2;

    typedef enum logic [1:0] {
        sweep_up   = 2'b00,
        sweep_down = 2'b01
    } sweep_dir_type;

    function automatic logic [6:0] amplitude_of(input logic [1:0] code);
        return 7'h04 << code;
    endfunction : amplitude_of
endpackage : osc_trim_pkg
`default_nettype wire

// ### src/slow_clock_divider.sv
`default_nettype none
module slow_clock_divider (
    input  wire logic slow_clk_tick,
    input  wire logic core_clk,
    input  wire logic rst,
    output logic      slow_quarter_tick
);
    logic [1:0] count;
    logic [1:0] next_count;
    logic       tick_out;
    logic       next_tick_out;

    always_comb begin
        next_count    = count;
        next_tick_out = 1'b0;
        if (slow_clk_tick) begin
            if (count == osc_trim_pkg::slow_div_ratio_m1) begin
                next_count    = 2'h0;
                next_tick_out = 1'b1;
            end else begin
                next_count = count + 2'h1;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            count    <= 2'h0;
            tick_out <= 1'b0;
        end else begin
            count    <= next_count;
            tick_out <= next_tick_out;
        end
    end

    assign slow_quarter_tick = tick_out;
endmodule : slow_clock_divider
`default_nettype wire

// ### src/spread_sweep.sv
`default_nettype none
module spread_sweep (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       fast_osc_tick,
    input  wire logic [3:0] sweep_rate,
    input  wire logic [1:0] sweep_amplitude,
    input  wire logic [7:0] fine_trim_value,
    output logic [7:0]      fine_trim_word,
    output logic [6:0]      sweep_offset_abs,
    output logic            sweep_active
);
    logic signed [7:0]         offset;
    logic signed [7:0]         next_offset;
    logic [4:0]                interval;
    logic [4:0]                next_interval;
    osc_trim_pkg::sweep_dir_type dir;
    osc_trim_pkg::sweep_dir_type next_dir;
    logic [7:0]                word;
    logic [7:0]                next_word;
    logic signed [7:0]         amp;
    logic signed [9:0]         sum;

    always_comb begin
        amp           = $signed({1'b0, osc_trim_pkg::amplitude_of(sweep_amplitude)});
        next_offset   = offset;
        next_interval = interval;
        next_dir      = dir;
        if (sweep_rate == 4'h0) begin
            next_offset   = 8'sh00;
            next_interval = 5'h00;
            next_dir      = osc_trim_pkg::sweep_up;
        end else if (fast_osc_tick) begin
            // a step every 2*rate ticks plus a one-step dwell at each end
            // makes the sweep 4*rate*(2*amp+1) ticks long
            if (interval + 5'h01 >= {sweep_rate, 1'b0}) begin
                next_interval = 5'h00;
                case (dir)
                    osc_trim_pkg::sweep_up: begin
                        if (offset >= amp) begin
                            // hold the peak for one step before turning
                            next_dir    = osc_trim_pkg::sweep_down;
                        end else begin
                            next_offset = offset + 8'sh01;
                        end
                    end
                    default: begin
                        if (offset <= -amp) begin
                            next_dir    = osc_trim_pkg::sweep_up;
                        end else begin
                            next_offset = offset - 8'sh01;
                        end
                    end
                endcase
                // amplitude change mid-sweep: pull back inside the new range
                if (next_offset > amp) next_offset = amp;
                if (next_offset < -amp) next_offset = -amp;
            end else begin
                next_interval = interval + 5'h01;
            end
        end
        sum = $signed({2'b00, fine_trim_value}) + 10'(next_offset);
        if (sum < 10'sd0) begin
            next_word = 8'h00;
        end else if (sum > 10'sd255) begin
            next_word = 8'hff;
        end else begin
            next_word = sum[7:0];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            offset   <= 8'sh00;
            interval <= 5'h00;
            dir      <= osc_trim_pkg::sweep_up;
            word     <= osc_trim_pkg::fine_trim_reset;
        end else begin
            offset   <= next_offset;
            interval <= next_interval;
            dir      <= next_dir;
            word     <= next_word;
        end
    end

    assign fine_trim_word   = word;
    assign sweep_offset_abs = offset[7] ? 7'(-offset) : offset[6:0];
    assign sweep_active     = (sweep_rate != 4'h0);
endmodule : spread_sweep
`default_nettype wire

// ### tb/osc_trim_props.sv
`default_nettype none
module osc_trim_props (
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic       fast_osc_tick,
    input wire logic       slow_clk_tick,
    input wire logic       cpu_stop_or_sleep,
    input wire logic       s_axi_bvalid,
    input wire logic [1:0] coarse_trim,
    input wire logic [7:0] trim_drive_out,
    input wire logic [4:0] slow_trim_value,
    input wire logic       fast_osc_enable,
    input wire logic       slow_osc_enable,
    input wire logic       slow_quarter_tick
);
    timeunit 1ns;
    timeprecision 1ps;
    // slow ticks seen since the last quarter pulse
    logic [2:0] ticks_seen;
    logic [2:0] next_ticks_seen;

    always_comb begin
        next_ticks_seen = ticks_seen + {2'h0, slow_clk_tick};
        if (slow_quarter_tick) begin
            next_ticks_seen = {2'h0, slow_clk_tick};
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ticks_seen <= 3'h0;
        end else begin
            ticks_seen <= next_ticks_seen;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    // a write lands two edges before the drive word can move
    sequence sweep_move;
        $changed(trim_drive_out) && !$past(s_axi_bvalid) && !$past(s_axi_bvalid, 2);
    endsequence

    AST_SLOW_ALWAYS_ON: assert property (slow_osc_enable)
        else $error("slow oscillator disabled");
    AST_WAKE_RESTARTS: assert property (!cpu_stop_or_sleep |=> fast_osc_enable)
        else $error("fast oscillator stopped while awake");
    AST_RESET_TRIMS: assert property ($fell(rst) |-> coarse_trim == 2'h1
        && trim_drive_out == 8'h80 && slow_trim_value == 5'h10)
        else $error("trim outputs wrong after reset");
    AST_STEP_BY_ONE: assert property (sweep_move |->
        trim_drive_out == $past(trim_drive_out) + 8'h1
        || trim_drive_out == $past(trim_drive_out) - 8'h1)
        else $error("sweep moved by more than one step");
    AST_STEP_AFTER_TICK: assert property (sweep_move |->
        $past(fast_osc_tick) || $past(fast_osc_tick, 2) || $past(fast_osc_tick, 3))
        else $error("sweep moved without a fast tick");
    AST_QUARTER_AFTER_TICK: assert property (slow_quarter_tick |-> $past(slow_clk_tick))
        else $error("quarter pulse without slow tick");
    AST_QUARTER_EVERY_FOURTH: assert property (slow_quarter_tick |-> ticks_seen == 3'h4)
        else $error("quarter pulse not on fourth slow tick");
    AST_COARSE_BY_WRITE: assert property ($changed(coarse_trim) |->
        s_axi_bvalid || $past(s_axi_bvalid))
        else $error("coarse trim moved without a write");
    AST_SLOW_TRIM_BY_WRITE: assert property ($changed(slow_trim_value) |->
        s_axi_bvalid || $past(s_axi_bvalid))
        else $error("slow trim moved without a write");

    cover property (slow_quarter_tick);
    cover property (sweep_move);
    cover property ($fell(fast_osc_enable));
endmodule : osc_trim_props

bind osc_trim_spread_spectrum osc_trim_props props (
    .core_clk, .rst, .fast_osc_tick, .slow_clk_tick, .cpu_stop_or_sleep, .s_axi_bvalid,
    .coarse_trim, .trim_drive_out, .slow_trim_value, .fast_osc_enable, .slow_osc_enable,
    .slow_quarter_tick
);
`default_nettype wire

// ### tb/osc_analog_model.sv
`default_nettype none
module osc_analog_model #(
    parameter int fast_div = 2,
    parameter int slow_div = 5
) (
    input  wire logic core_clk,
    input  wire logic fast_osc_enable,
    input  wire logic slow_osc_enable,
    output var logic  fast_osc_tick,
    output var logic  slow_clk_tick
);
    timeunit 1ns;
    timeprecision 1ps;
    int fast_phase = 0;
    int slow_phase = 0;

    initial begin
        fast_osc_tick = 1'b0;
        slow_clk_tick = 1'b0;
    end

    always @(posedge core_clk) begin
        // a stopped oscillator makes no edges at all
        if (fast_osc_enable === 1'b1) begin
            fast_phase <= (fast_phase + 1) % fast_div;
        end
        fast_osc_tick <= fast_osc_enable === 1'b1 && fast_phase == fast_div - 1;
        // runs whenever enabled, which should be always
        slow_phase <= (slow_phase + 1) % slow_div;
        slow_clk_tick <= slow_osc_enable === 1'b1 && slow_phase == slow_div - 1;
    end
endmodule : osc_analog_model
`default_nettype wire

// ### tb/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [17:0] coarse_addr = 18'h28004;
    localparam logic [17:0] fine_addr   = 18'h28008;
    localparam logic [17:0] slow_addr   = 18'h2801c;
    localparam logic [17:0] hole_addr   = 18'h28030;
    localparam logic [17:0] stat_addr   = 18'h28020;
    // 0x02 and 0xfe ignore the headroom advice on purpose to force clipping
    localparam logic [7:0] fine_tab [6] = '{8'h80, 8'h80, 8'h80, 8'h80, 8'h02, 8'hfe};
    localparam logic [7:0] lo_tab   [6] = '{8'h7c, 8'h78, 8'h70, 8'h60, 8'h00, 8'hde};
    localparam logic [7:0] hi_tab   [6] = '{8'h84, 8'h88, 8'h90, 8'ha0, 8'h22, 8'hff};
    localparam logic [1:0] code_tab [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h3};
    localparam logic [3:0] rate_tab [2] = '{4'h3, 4'h1};
    logic        core_clk, rst, fast_osc_tick, slow_clk_tick, cpu_stop_or_sleep;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [17:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, coarse_trim;
    logic [7:0]  trim_drive_out, lo, hi, held;
    logic [4:0]  slow_trim_value;
    logic [6:0]  off;
    logic        fast_osc_enable, slow_osc_enable, slow_quarter_tick;
    int          fails = 0;
    int          tests_run = 0;
    int          ticks, pulses, n;

    osc_trim_spread_spectrum uut (
        .core_clk, .rst, .fast_osc_tick, .slow_clk_tick, .cpu_stop_or_sleep,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .coarse_trim, .trim_drive_out, .slow_trim_value,
        .fast_osc_enable, .slow_osc_enable, .slow_quarter_tick
    );
    osc_analog_model #(.fast_div(2), .slow_div(5)) partner (
        .core_clk, .fast_osc_enable, .slow_osc_enable, .fast_osc_tick, .slow_clk_tick
    );

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want) begin
            fails++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
        end
    endtask : check

    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run

    task automatic step();
        @(posedge core_clk);
        n++;
        if (n > 3000) begin
            fails++;
            $display("unexpected at %0t: wait ran out", $time);
            complete_run();
        end
    endtask : step

    task automatic axi_write(input logic [17:0] addr, input logic [31:0] data,
                             input logic [1:0] resp);
        n = 0;
        s_axi_awaddr <= addr;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= data;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        // the condition sees each valid as it stood at the edge just sampled
        do begin
            step();
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while ((s_axi_awvalid && s_axi_awready !== 1'b1)
                   || (s_axi_wvalid && s_axi_wready !== 1'b1));
        do step(); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        check(s_axi_bresp, resp);
        @(posedge core_clk);
    endtask : axi_write

    task automatic axi_read(input logic [17:0] addr, input logic [31:0] want,
                            input logic [1:0] resp);
        n = 0;
        s_axi_araddr <= addr;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do step(); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do step(); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        check(s_axi_rdata, want);
        check(s_axi_rresp, resp);
        @(posedge core_clk);
    endtask : axi_read

    // rate zero first so every sweep starts from the centre
    task automatic set_sweep(input logic [7:0] fine, input logic [7:0] ctrl);
        axi_write(coarse_addr, 32'h01, 2'h0);
        axi_write(fine_addr, {24'h0, fine}, 2'h0);
        axi_write(coarse_addr, {24'h0, ctrl}, 2'h0);
    endtask : set_sweep

    task automatic sweep_span(input int cycles);
        lo = 8'hff;
        hi = 8'h00;
        repeat (cycles) begin
            @(posedge core_clk);
            if (trim_drive_out < lo) lo = trim_drive_out;
            if (trim_drive_out > hi) hi = trim_drive_out;
        end
    endtask : sweep_span

    // fast ticks from one arrival at the peak to the next
    task automatic count_period(input logic [7:0] peak);
        n = 0;
        ticks = 0;
        while (trim_drive_out !== peak) step();
        do begin
            step();
            if (fast_osc_tick === 1'b1) ticks++;
        end while (trim_drive_out === peak || n < 4);
        while (trim_drive_out !== peak) begin
            step();
            if (fast_osc_tick === 1'b1) ticks++;
        end
    endtask : count_period

    initial begin
        rst = 1'b1;
        cpu_stop_or_sleep = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        s_axi_awaddr = 18'h0;
        s_axi_araddr = 18'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        check(slow_osc_enable, 1'b1);
        axi_read(coarse_addr, 32'h01, 2'h0);
        axi_read(fine_addr, 32'h80, 2'h0);
        axi_read(slow_addr, 32'h10, 2'h0);
        axi_read(hole_addr, 32'h0, 2'h2);
        axi_write(hole_addr, 32'h5a, 2'h2);
        $display("test reset_and_map done");
        for (int c = 0; c < 4; c++) begin
            axi_write(coarse_addr, c, 2'h0);
            repeat (2) @(posedge core_clk);
            check(coarse_trim, c[1:0]);
        end
        axi_write(slow_addr, 32'hff, 2'h0);
        axi_read(slow_addr, 32'h1f, 2'h0);
        check(slow_trim_value, 5'h1f);
        $display("test trim_fields done");
        set_sweep(8'h40, 8'h0d);
        sweep_span(300);
        check(lo, 8'h40);
        check(hi, 8'h40);
        for (int i = 0; i < 6; i++) begin
            set_sweep(fine_tab[i], {4'h1, code_tab[i], 2'h1});
            sweep_span(16 * (4 << code_tab[i]) + 40);
            check(lo, lo_tab[i]);
            check(hi, hi_tab[i]);
        end
        $display("test sweep_span done");
        for (int i = 0; i < 2; i++) begin
            set_sweep(8'h80, {rate_tab[i], code_tab[i], 2'h1});
            count_period(8'h80 + (8'h04 << code_tab[i]));
            check(ticks, 4 * rate_tab[i] * ((8 << code_tab[i]) + 1));
        end
        $display("test sweep_period done");
        cpu_stop_or_sleep <= 1'b1;
        repeat (3) @(posedge core_clk);
        check(fast_osc_enable, 1'b0);
        held = trim_drive_out;
        ticks = 0;
        repeat (20) begin
            @(posedge core_clk);
            if (fast_osc_tick !== 1'b0) ticks++;
        end
        check(ticks, 0);
        check(trim_drive_out, held);
        off = held >= 8'h80 ? 7'(held - 8'h80) : 7'(8'h80 - held);
        axi_read(stat_addr, {7'h00, 1'b1, 1'b0, off, held, 8'h01}, 2'h0);
        cpu_stop_or_sleep <= 1'b0;
        repeat (3) @(posedge core_clk);
        check(fast_osc_enable, 1'b1);
        $display("test sleep done");
        n = 0;
        while (slow_quarter_tick !== 1'b1) step();
        ticks = 0;
        pulses = 0;
        while (pulses < 10) begin
            step();
            if (slow_clk_tick === 1'b1) ticks++;
            if (slow_quarter_tick === 1'b1) pulses++;
        end
        check(ticks, 40);
        $display("test slow_quarter done");
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        check(trim_drive_out, 8'h80);
        check(coarse_trim, 2'h1);
        check(slow_trim_value, 5'h10);
        $display("test second_reset done");
        complete_run();
    end
endmodule : testbench
`default_nettype wire
